// ==== nfm_pkg.sv ====
// Package for the file address mapper: file selections, memory layout and request carriers.
package nfm_pkg;

   localparam int ADDR_W = 16;

   // File selection state, one-hot.
   typedef enum logic [3:0] {
      NFM_SEL_NONE = 4'h1,
      NFM_SEL_APP  = 4'h2,
      NFM_SEL_CC   = 4'h4,
      NFM_SEL_NDEF = 4'h8
   } nfm_sel_t;

   // Select command targets as carried on the select port (selTarget).
   typedef enum logic [1:0] {
      NFM_TGT_APP  = 2'h0,
      NFM_TGT_CC   = 2'h1,
      NFM_TGT_NDEF = 2'h2,
      NFM_TGT_NONE = 2'h3
   } nfm_tgt_t;

   localparam logic [15:0] BLOCK_BYTES = 16'h0010;
   localparam logic [15:0] CC_PHYS_BASE = 16'h0180;
   localparam logic [15:0] CC_BLOCK = 16'h0018;
   localparam logic [15:0] LEN_FIELD_PHYS_BASE = 16'h000C;
   localparam logic [15:0] LEN_FIELD_SIZE = 16'h0002;
   localparam logic [15:0] MSG_PHYS_BASE = 16'h0010;
   localparam logic [15:0] MSG_LAST_BLOCK = 16'h0017;

   // Status words returned to the command layer.
   localparam logic [15:0] SW_OK = 16'h9000;
   localparam logic [15:0] SW_NOT_SELECTED = 16'h6986;
   localparam logic [15:0] SW_OUT_OF_RANGE = 16'h6A82;

   // Translation request: start offset and byte count of an access in the selected file.
   typedef struct packed {
      logic [15:0] selAddr;
      logic [7:0] len;
   } nfm_req_t;

   // Translation answer for the first byte of the access.
   typedef struct packed {
      logic [15:0] physAddr;
      logic [15:0] statusWord;
      logic ok;
   } nfm_rsp_t;

endpackage

// ==== nfm_file_mapper.sv ====
// File address mapper: translates file select addresses to nonvolatile memory addresses.
// A range access is walked byte by byte; each byte gets its own physical address so
// one command can cross the gap between length field and body.
// A select command that arrives during a walk is dropped rather than queued, so the
// reader must wait for the end of an access before changing files.
// Requests that arrive during a walk get no answer at all; the command layer above
// must keep to one access at a time.
`timescale 1ns/1ns

module nfm_file_mapper (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic selValid,
   input wire nfm_pkg::nfm_tgt_t selTarget,
   input wire logic reqValid,
   input wire nfm_pkg::nfm_req_t req,
   input wire logic byteNext,
   output nfm_pkg::nfm_rsp_t rsp,
   output logic rspValid,
   output logic byteValid,
   output logic [15:0] byteAddr,
   output logic accessDone,
   output logic [3:0] selState
);

   // The external reset is asserted asynchronously. Its release is passed through
   // two flip-flops so that every register below leaves reset on the same clock edge,
   // while an assertion still clears them at once.
   logic rstMeta_q;
   logic rstSync_q;
   logic rstN;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end
   assign rstN = rstSync_q;

   // Current file selection. It starts with no file chosen, so any access before a
   // select command is refused.
   nfm_pkg::nfm_sel_t sel_q;
   nfm_pkg::nfm_sel_t sel_d;

   // Selection changes only on a select command.
   always_comb begin
      sel_d = sel_q;
      if (selValid) begin
         case (selTarget)
            nfm_pkg::NFM_TGT_APP: sel_d = nfm_pkg::NFM_SEL_APP;
            nfm_pkg::NFM_TGT_CC: sel_d = nfm_pkg::NFM_SEL_CC;
            nfm_pkg::NFM_TGT_NDEF: sel_d = nfm_pkg::NFM_SEL_NDEF;
            default: sel_d = nfm_pkg::NFM_SEL_NONE;
         endcase
      end
   end

   // File extents in bytes. The container is one block; the message file is the
   // two length bytes plus blocks 1 to 23.
   localparam logic [16:0] CC_SIZE = {1'b0, nfm_pkg::BLOCK_BYTES};
   // The sizes are kept at 17 bits so that the end of an access near the top of the
   // 16-bit offset range cannot wrap around and look as if it were inside the file.
   localparam logic [16:0] NDEF_SIZE = {1'b0, nfm_pkg::LEN_FIELD_SIZE} +
      17'({nfm_pkg::MSG_LAST_BLOCK, 4'h0}) + 17'({1'b0, nfm_pkg::BLOCK_BYTES})
      - 17'({1'b0, nfm_pkg::MSG_PHYS_BASE});

   // Range check for a whole request. The access is taken only when every byte of it
   // lies inside the selected file; a partial access is never started, so memory is
   // not touched by a refused command.
   wire isCc = (sel_q == nfm_pkg::NFM_SEL_CC);
   wire isNdef = (sel_q == nfm_pkg::NFM_SEL_NDEF);
   wire [16:0] reqEnd = {1'b0, req.selAddr} + {9'h000, req.len};
   wire [16:0] fileSize = isCc ? CC_SIZE : NDEF_SIZE;
   wire fileOpen = isCc | isNdef;
   wire lenZero = (req.len == 8'h00);
   wire inRange = !lenZero && (reqEnd <= fileSize);

   // Walk state: the select offset of the byte on offer, the bytes still to go and
   // which file the walk belongs to. The file is latched at the start so that the
   // translation of one access cannot change halfway through.
   logic [15:0] walkAddr_q;
   logic [7:0] walkLeft_q;
   logic walking_q;
   logic walkCc_q;

   // Per-byte translation for the byte currently walked.
   // The container maps straight onto its block. The message file has two regions:
   // the length field at bytes 12 and 13 of block 0 and the body from block 1 on, so the
   // two bytes between them are skipped.
   wire inLenField = (walkAddr_q < nfm_pkg::LEN_FIELD_SIZE);
   wire [15:0] ccPhys = nfm_pkg::CC_PHYS_BASE + walkAddr_q;
   wire [15:0] lenFieldPhys = nfm_pkg::LEN_FIELD_PHYS_BASE + walkAddr_q;
   wire [15:0] msgPhys = nfm_pkg::MSG_PHYS_BASE + walkAddr_q
      - nfm_pkg::LEN_FIELD_SIZE;
   wire [15:0] ndefPhys = inLenField ? lenFieldPhys : msgPhys;
   wire [15:0] curPhys = walkCc_q ? ccPhys : ndefPhys;

   // Address the first byte as the answer, so a caller can check the start mapping.
   // This is worked from the request itself, since the walk registers are loaded on
   // the same edge that launches the first byte address.
   wire firstLen = (req.selAddr < nfm_pkg::LEN_FIELD_SIZE);
   wire [15:0] startPhys = isCc ? (nfm_pkg::CC_PHYS_BASE + req.selAddr) :
      firstLen ? (nfm_pkg::LEN_FIELD_PHYS_BASE + req.selAddr) :
      (nfm_pkg::MSG_PHYS_BASE + req.selAddr - nfm_pkg::LEN_FIELD_SIZE);

   // Status for a request seen while idle. A missing selection is reported before a
   // range fault, because the file extent means nothing without a file.
   wire accept = reqValid && !walking_q && fileOpen && inRange;
   wire [15:0] swNext = !fileOpen ? nfm_pkg::SW_NOT_SELECTED :
      !inRange ? nfm_pkg::SW_OUT_OF_RANGE : nfm_pkg::SW_OK;
   wire stepByte = walking_q && byteNext;
   wire lastByte = (walkLeft_q == 8'h01);

   // Selection, answer and walk registers. The answer is given once per request seen
   // while idle; during a walk a request is ignored entirely, which keeps the answer
   // of the running access standing until the walk has ended.
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         sel_q <= nfm_pkg::NFM_SEL_NONE;
         walking_q <= 1'b0;
         walkCc_q <= 1'b0;
         walkAddr_q <= 16'h0000;
         walkLeft_q <= 8'h00;
         rsp <= '0;
         rspValid <= 1'b0;
         accessDone <= 1'b0;
      end else begin
         // A new selection is held off while a walk is under way.
         sel_q <= walking_q ? sel_q : sel_d;
         rspValid <= reqValid && !walking_q;
         accessDone <= stepByte && lastByte;
         if (reqValid && !walking_q) begin
            rsp.physAddr <= accept ? startPhys : 16'h0000;
            rsp.statusWord <= swNext;
            rsp.ok <= accept;
         end
         if (accept) begin
            walking_q <= 1'b1;
            walkCc_q <= isCc;
            walkAddr_q <= req.selAddr;
            walkLeft_q <= req.len;
         end else if (stepByte) begin
            walkAddr_q <= walkAddr_q + 16'h0001;
            walkLeft_q <= walkLeft_q - 8'h01;
            walking_q <= !lastByte;
         end
      end
   end

   // Byte address outputs registered from the walk state of the next cycle.
   // The next address is worked out ahead so that byteAddr comes straight from a
   // flip-flop; the cost is a second copy of the translation for the stepped offset.
   // Without a step the address simply stands, which lets a slow consumer stall.
   logic [15:0] nextAddr;
   logic nextValid;
   always_comb begin
      nextValid = walking_q && !(stepByte && lastByte);
      nextAddr = curPhys;
      if (stepByte && !lastByte) begin
         if (walkCc_q) begin
            nextAddr = ccPhys + 16'h0001;
         end else if (walkAddr_q + 16'h0001 < nfm_pkg::LEN_FIELD_SIZE) begin
            nextAddr = lenFieldPhys + 16'h0001;
         end else begin
            // Crossing from the length field into the body lands on block 1.
            nextAddr = nfm_pkg::MSG_PHYS_BASE + walkAddr_q + 16'h0001
               - nfm_pkg::LEN_FIELD_SIZE;
         end
      end
      if (accept) begin
         nextValid = 1'b1;
         nextAddr = startPhys;
      end
   end

   // Output registers. selState follows the selection that sel_q will hold after
   // this edge, so the reported state and the translation disagree only when a select command comes in the same cycle as an accepted request.
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         byteValid <= 1'b0;
         byteAddr <= 16'h0000;
         selState <= nfm_pkg::NFM_SEL_NONE;
      end else begin
         byteValid <= nextValid;
         byteAddr <= nextAddr;
         selState <= walking_q ? sel_q : sel_d;
      end
   end

endmodule

// ==== nfm_monitor.sv ====
// Checker on the file address mapper ports.
`timescale 1ns/1ns
module nfm_monitor (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic selValid,
   input wire nfm_pkg::nfm_tgt_t selTarget,
   input wire nfm_pkg::nfm_req_t req,
   input wire nfm_pkg::nfm_rsp_t rsp,
   input wire logic rspValid,
   input wire logic byteValid,
   input wire logic [15:0] byteAddr,
   input wire logic [3:0] selState
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   property p_cc;
      rspValid && rsp.ok && selState == 4'h4 |-> rsp.physAddr == $past(req.selAddr) + 16'h0180;
   endproperty
   a_cc: assert property (p_cc) else $error("cc address wrong");
   property p_len;
      rspValid && rsp.ok && selState == 4'h8 && $past(req.selAddr) < 16'h0002
         |-> rsp.physAddr == $past(req.selAddr) + 16'h000C;
   endproperty
   a_len: assert property (p_len) else $error("length field address wrong");
   property p_msg;
      rspValid && rsp.ok && selState == 4'h8 && $past(req.selAddr) > 16'h0001
         |-> rsp.physAddr == $past(req.selAddr) + 16'h000E;
   endproperty
   a_msg: assert property (p_msg) else $error("body address wrong");
   property p_gap;
      byteValid && selState == 4'h8 |-> byteAddr != 16'h000E && byteAddr != 16'h000F;
   endproperty
   a_gap: assert property (p_gap) else $error("gap touched");
   property p_none;
      rspValid && selState == 4'h1 |-> !rsp.ok && rsp.statusWord == 16'h6986;
   endproperty
   a_none: assert property (p_none) else $error("unselected access taken");
   property p_nowalk;
      rspValid && !rsp.ok |-> !byteValid;
   endproperty
   a_nowalk: assert property (p_nowalk) else $error("refused access walked");
   property p_first;
      rspValid && rsp.ok |-> byteValid && byteAddr == rsp.physAddr;
   endproperty
   a_first: assert property (p_first) else $error("first byte address wrong");
   property p_sel;
      selValid && !byteValid && selTarget == nfm_pkg::NFM_TGT_NDEF |=> selState == 4'h8;
   endproperty
   a_sel: assert property (p_sel) else $error("selection not taken");
endmodule
bind nfm_file_mapper nfm_monitor i_nfm_monitor (.sys_clk(sys_clk), .rst_b(rst_b),
   .selValid(selValid), .selTarget(selTarget), .req(req), .rsp(rsp), .rspValid(rspValid),
   .byteValid(byteValid), .byteAddr(byteAddr), .selState(selState));

// ==== nfm_byte_sink.sv ====
// Byte consumer model on the memory side of the mapper.
`timescale 1ns/1ns
module nfm_byte_sink (
   input wire logic sys_clk,
   input wire logic byteValid,
   input wire logic slow,
   output logic byteNext
);
   // A slow consumer takes a byte only every other cycle, so addresses must hold across stalls.
   initial byteNext = 1'b0;
   always @(negedge sys_clk) byteNext <= byteValid && !(slow && byteNext);
endmodule

// ==== nfm_file_mapper_tb.sv ====
// Self-checking bench for the file address mapper.
`timescale 1ns/1ns
module nfm_file_mapper_tb;
   typedef struct packed {logic [1:0] tgt; logic [15:0] a; logic [7:0] n; logic [15:0] sw;} nfm_row_t;
   logic sys_clk = 1'b0, rst_b = 1'b0, selValid = 1'b0, reqValid = 1'b0, slow = 1'b0;
   logic byteNext, rspValid, byteValid, accessDone;
   logic [15:0] byteAddr, nBytes;
   logic [3:0] selState;
   nfm_pkg::nfm_tgt_t selTarget = nfm_pkg::NFM_TGT_APP;
   nfm_pkg::nfm_req_t req = '0;
   nfm_pkg::nfm_rsp_t rsp;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   nfm_row_t rows [9] = '{'{2'h1, 16'h0000, 8'h10, 16'h9000}, '{2'h1, 16'h000F, 8'h02, 16'h6A82},
      '{2'h2, 16'h0000, 8'h03, 16'h9000}, '{2'h2, 16'h0000, 8'h02, 16'h9000},
      '{2'h2, 16'h0002, 8'h03, 16'h9000}, '{2'h2, 16'h0171, 8'h01, 16'h9000},
      '{2'h2, 16'h0171, 8'h02, 16'h6A82}, '{2'h2, 16'h0001, 8'h00, 16'h6A82},
      '{2'h3, 16'h0000, 8'h01, 16'h6986}};
   nfm_file_mapper i_nfm_file_mapper (.sys_clk(sys_clk), .rst_b(rst_b), .selValid(selValid),
      .selTarget(selTarget), .reqValid(reqValid), .req(req), .byteNext(byteNext), .rsp(rsp),
      .rspValid(rspValid), .byteValid(byteValid), .byteAddr(byteAddr),
      .accessDone(accessDone), .selState(selState));
   nfm_byte_sink i_nfm_byte_sink (.sys_clk(sys_clk), .byteValid(byteValid), .slow(slow),
      .byteNext(byteNext));
   initial forever #5 sys_clk = ~sys_clk;
   function automatic logic [15:0] phys(logic [1:0] t, logic [15:0] o);
      return (t == 2'h1) ? 16'h0180 + o : (o < 16'h0002) ? 16'h000C + o : 16'h000E + o;
   endfunction
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      $display("checked %0d bad %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic sel(logic [1:0] t);
      @(negedge sys_clk);
      selValid = 1'b1;
      selTarget = nfm_pkg::nfm_tgt_t'(t);
      @(negedge sys_clk);
      selValid = 1'b0;
      @(negedge sys_clk);
      chk({12'h000, selState}, (t == 2'h3) ? 16'h0001 : 16'h0002 << t);
   endtask
   task automatic acc(nfm_row_t r);
      @(negedge sys_clk);
      reqValid = 1'b1;
      req = '{r.a, r.n};
      @(negedge sys_clk);
      reqValid = 1'b0;
      chk({15'h0000, rspValid}, 16'h0001);
      chk(rsp.statusWord, r.sw);
      chk({15'h0000, rsp.ok}, {15'h0000, r.sw == 16'h9000});
      chk(rsp.physAddr, (r.sw == 16'h9000) ? phys(r.tgt, r.a) : 16'h0000);
      nBytes = 16'h0000;
      for (int k = 0; k < 800 && r.sw == 16'h9000 && accessDone !== 1'b1; k++) begin
         @(posedge sys_clk);
         if ((byteValid & byteNext) === 1'b1) begin
            chk(byteAddr, phys(r.tgt, r.a + nBytes));
            nBytes++;
         end
      end
      chk(nBytes, (r.sw == 16'h9000) ? {8'h00, r.n} : 16'h0000);
      chk({15'h0000, accessDone}, {15'h0000, r.sw == 16'h9000});
   endtask
   initial begin
      repeat (12) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (3) @(negedge sys_clk);
      foreach (rows[i]) begin
         slow = i[0];
         sel(rows[i].tgt);
         acc(rows[i]);
      end
      // Container layout and the empty message file as the reader writes them.
      sel(2'h1);
      acc('{2'h1, 16'h0000, 8'h0F, 16'h9000});
      sel(2'h2);
      acc('{2'h2, 16'h0000, 8'h05, 16'h9000});
      sel(2'h0);
      acc('{2'h0, 16'h0000, 8'h01, 16'h6986});
      // A reset in mid-walk must drop both the walk and the selection.
      sel(2'h1);
      reqValid = 1'b1;
      req = '{16'h0000, 8'h10};
      @(negedge sys_clk);
      reqValid = 1'b0;
      rst_b = 1'b0;
      @(negedge sys_clk);
      chk({12'h000, selState}, 16'h0001);
      chk({15'h0000, byteValid}, 16'h0000);
      tally_and_finish();
   end
endmodule
